// [hdl/acr_capability_regs.sv]
// Purpose: read-only capability registers and the queue-side gating they imply
// Assumes: register port and queue inputs are synchronous to clk
// Notes:   capability values are fixed by parameters; writes are acknowledged and dropped
//          read data falls back to zero one cycle after it is returned, unless another read follows
`timescale 1ns/1ps
module acr_capability_regs #(
	parameter logic        CAP_FLUSH_CC   = 1'b1,     // flush cache control
	parameter logic        CAP_MEM_CC     = 1'b1,     // write cache control
	parameter logic        CAP_OVERLAP    = 1'b1,     // overlapping move
	parameter logic        CAP_BLOCK      = 1'b1,     // block on fault
	parameter logic        CAP_OCC_INT    = 1'b1,     // occupancy interrupts
	parameter logic        CAP_OCC        = 1'b1,     // occupancy reporting
	parameter logic        CAP_PRIO       = 1'b1,     // queue priority
	parameter logic        CAP_ATS        = 1'b1,     // per-queue ATS disable
	parameter logic        CAP_DEDICATED  = 1'b1,     // dedicated mode
	parameter logic        CAP_SHARED     = 1'b1,     // shared mode
	parameter logic [3:0]  CFG_SIZE_N     = 4'h0,     // config size exponent
	parameter logic [7:0]  NUM_QUEUES     = 8'h08,    // number of queues
	parameter logic [15:0] TOTAL_SIZE     = 16'h0080  // total queue entries
) (
	input  wire logic                           clk,           // 40 MHz clock
	input  wire logic                           rst_n,         // async reset
	// register port
	input  wire logic                           mmio_rd,       // read strobe
	input  wire logic                           mmio_wr,       // write strobe
	input  wire logic [acr_pkg::ADDR_W-1:0]     mmio_addr,     // byte address
	input  wire logic [acr_pkg::DATA_W-1:0]     mmio_wdata,    // write data, dropped
	output logic      [acr_pkg::DATA_W-1:0]     mmio_rdata,    // read data
	output logic                                mmio_ack,      // access done pulse
	// descriptor attributes and decisions
	input  wire logic                           desc_valid,    // descriptor valid
	input  wire logic                           desc_is_move,  // memory move op
	input  wire logic                           desc_is_flush, // cache flush op
	input  wire logic                           desc_wr_mem,   // writes memory
	input  wire logic                           desc_cc_flag,  // cache control flag
	input  wire logic                           desc_overlap,  // buffers overlap
	input  wire logic                           desc_block,    // block-on-fault flag
	input  wire logic                           queue_block,   // queue block enable
	input  wire logic                           desc_fault,    // page fault seen
	output logic                                pol_valid,     // decision pulse
	output logic                                pol_evict,     // flush evicts lines
	output logic                                pol_cache,     // write steers cache
	output logic                                pol_ovl_err,   // overlap error
	output logic                                pol_block,     // fault blocks
	output logic                                pol_stop,      // fault stops op
	// queue configuration fields
	input  wire logic [7:0]                     q_index,       // queue selected
	input  wire logic [15:0]                    q_occupancy,   // live queue fill
	input  wire logic [15:0]                    q_occ_limit,   // occupancy limit
	input  wire logic                           q_occ_int_en,  // occupancy int enable
	input  wire logic [3:0]                     q_priority,    // configured priority
	input  wire logic                           q_ats_dis,     // per-queue ATS off
	input  wire logic                           ats_enable,    // global ATS enable
	input  wire logic                           q_shared,      // queue set shared
	output logic      [15:0]                    q_occ_report,  // occupancy field
	output logic                                q_occ_hit,     // limit reached
	output logic      [3:0]                     q_prio_eff,    // priority in use
	output logic                                q_ats_use,     // queue uses ATS
	output logic                                q_mode_bad,    // mode not offered
	output logic                                q_index_bad,   // no such queue
	output logic      [acr_pkg::CFG_OFFSET_W-1:0] q_cfg_offset // config reg offset
);

	// general_capabilities image, bits 63:4 unused and zero
	localparam logic [63:0] GEN_VALUE =
		(64'(CAP_FLUSH_CC) << acr_pkg::GC_FLUSH_CC_BIT) |
		(64'(CAP_MEM_CC)   << acr_pkg::GC_MEM_CC_BIT) |
		(64'(CAP_OVERLAP)  << acr_pkg::GC_OVERLAP_BIT) |
		(64'(CAP_BLOCK)    << acr_pkg::GC_BLOCK_FAULT_BIT);
	// queue_capabilities image, bits 63:54 and 47:28 unused and zero
	localparam logic [63:0] QUE_VALUE =
		(64'(CAP_OCC_INT)   << acr_pkg::QC_OCC_INT_BIT) |
		(64'(CAP_OCC)       << acr_pkg::QC_OCC_BIT) |
		(64'(CAP_PRIO)      << acr_pkg::QC_PRIO_BIT) |
		(64'(CAP_ATS)       << acr_pkg::QC_ATS_BIT) |
		(64'(CAP_DEDICATED) << acr_pkg::QC_DEDICATED_BIT) |
		(64'(CAP_SHARED)    << acr_pkg::QC_SHARED_BIT) |
		(64'(CFG_SIZE_N)    << acr_pkg::QC_CFG_SIZE_LSB) |
		(64'(NUM_QUEUES)    << acr_pkg::QC_NUM_QUEUES_LSB) |
		(64'(TOTAL_SIZE)    << acr_pkg::QC_TOTAL_SIZE_LSB);

	logic [63:0] rdata_r,    rdata_nxt;
	logic        ack_r,      ack_nxt;
	logic [15:0] occ_r,      occ_nxt;
	logic        hit_r,      hit_nxt;
	logic [3:0]  prio_r,     prio_nxt;
	logic        ats_r,      ats_nxt;
	logic        mode_r,     mode_nxt;
	logic        idx_r,      idx_nxt;
	logic [acr_pkg::CFG_OFFSET_W-1:0] cfg_r, cfg_nxt;

	// register port: reads at the two image offsets return the fixed images, other reads zero, writes change nothing
	always_comb begin
		ack_nxt   = 1'b0;
		rdata_nxt = acr_pkg::RDATA_RST;
		// every bit is read-only, so a write is acknowledged and dropped
		if (mmio_wr) begin
			ack_nxt = 1'b1;
		end
		// a read sharing its cycle with a write still returns data
		if (mmio_rd) begin
			ack_nxt = 1'b1;
			unique case (mmio_addr)
				acr_pkg::GENERAL_CAPABILITIES_OFS: rdata_nxt = GEN_VALUE;
				acr_pkg::QUEUE_CAPABILITIES_OFS:   rdata_nxt = QUE_VALUE;
				default:                           rdata_nxt = acr_pkg::RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= acr_pkg::RDATA_RST;
			ack_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
		end
	end

	// queue configuration fields as the device interprets them
	always_comb begin
		occ_nxt  = 16'h0000;
		hit_nxt  = 1'b0;
		prio_nxt = 4'h0;
		ats_nxt  = ats_enable;
		// undefined without support; zero keeps it deterministic
		if (CAP_OCC) begin
			occ_nxt = q_occupancy;
		end
		// without support, limit and enable are reserved, so they must not raise anything
		if (CAP_OCC_INT && q_occ_int_en && (q_occupancy >= q_occ_limit)) begin
			hit_nxt = 1'b1;
		end
		// an unsupported priority field is ignored, not passed on
		if (CAP_PRIO) begin
			prio_nxt = q_priority;
		end
		// without per-queue control only the global enable decides
		if (CAP_ATS && q_ats_dis) begin
			ats_nxt = 1'b0;
		end
		// software owns the mode choice; flag a mode that is not offered
		if (q_shared) begin
			mode_nxt = ~CAP_SHARED;
		end else begin
			mode_nxt = ~CAP_DEDICATED;
		end
		idx_nxt  = (q_index >= NUM_QUEUES);
		cfg_nxt  = acr_pkg::cfg_offset(q_index, CFG_SIZE_N);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			occ_r  <= 16'h0000;
			hit_r  <= 1'b0;
			prio_r <= 4'h0;
			ats_r  <= 1'b0;
			mode_r <= 1'b0;
			idx_r  <= 1'b0;
			cfg_r  <= '0;
		end else begin
			occ_r  <= occ_nxt;
			hit_r  <= hit_nxt;
			prio_r <= prio_nxt;
			ats_r  <= ats_nxt;
			mode_r <= mode_nxt;
			idx_r  <= idx_nxt;
			cfg_r  <= cfg_nxt;
		end
	end

	acr_desc_policy acr_desc_policy_inst (
		.clk           (clk),
		.rst_n         (rst_n),
		.cap_flush_cc  (CAP_FLUSH_CC),
		.cap_mem_cc    (CAP_MEM_CC),
		.cap_overlap   (CAP_OVERLAP),
		.cap_block     (CAP_BLOCK),
		.desc_valid    (desc_valid),
		.desc_is_move  (desc_is_move),
		.desc_is_flush (desc_is_flush),
		.desc_wr_mem   (desc_wr_mem),
		.desc_cc_flag  (desc_cc_flag),
		.desc_overlap  (desc_overlap),
		.desc_block    (desc_block),
		.queue_block   (queue_block),
		.desc_fault    (desc_fault),
		.pol_valid     (pol_valid),
		.pol_evict     (pol_evict),
		.pol_cache     (pol_cache),
		.pol_ovl_err   (pol_ovl_err),
		.pol_block     (pol_block),
		.pol_stop      (pol_stop)
	);

	assign mmio_rdata   = rdata_r;
	assign mmio_ack     = ack_r;
	assign q_occ_report = occ_r;
	assign q_occ_hit    = hit_r;
	assign q_prio_eff   = prio_r;
	assign q_ats_use    = ats_r;
	assign q_mode_bad   = mode_r;
	assign q_index_bad  = idx_r;
	assign q_cfg_offset = cfg_r;

endmodule : acr_capability_regs

// [hdl/acr_pkg.sv]
// Purpose: shared constants for the accelerator capability register bank
// Assumes: 64-bit register port, byte addressed, one aligned word per register
// Notes:   capability values themselves are top-level parameters
package acr_pkg;

	localparam int          ADDR_W                  = 8;
	localparam int          DATA_W                  = 64;

	localparam logic [7:0]  GENERAL_CAPABILITIES_OFS = 8'h10;
	localparam logic [7:0]  QUEUE_CAPABILITIES_OFS   = 8'h20;
	localparam logic [63:0] RDATA_RST               = 64'h0000000000000000;

	// general_capabilities fields
	localparam int          GC_FLUSH_CC_BIT         = 3;
	localparam int          GC_MEM_CC_BIT           = 2;
	localparam int          GC_OVERLAP_BIT          = 1;
	localparam int          GC_BLOCK_FAULT_BIT      = 0;

	// queue_capabilities fields
	localparam int          QC_OCC_INT_BIT          = 53;
	localparam int          QC_OCC_BIT              = 52;
	localparam int          QC_PRIO_BIT             = 51;
	localparam int          QC_ATS_BIT              = 50;
	localparam int          QC_DEDICATED_BIT        = 49;
	localparam int          QC_SHARED_BIT           = 48;
	localparam int          QC_CFG_SIZE_LSB         = 24;
	localparam int          QC_CFG_SIZE_W           = 4;
	localparam int          QC_NUM_QUEUES_LSB       = 16;
	localparam int          QC_NUM_QUEUES_W         = 8;
	localparam int          QC_TOTAL_SIZE_LSB       = 0;
	localparam int          QC_TOTAL_SIZE_W         = 16;

	localparam logic [4:0]  CFG_SIZE_BASE_EXP       = 5'h05;
	localparam int          CFG_OFFSET_W            = 28;

	// byte offset of a queue configuration register within its table
	function automatic logic [CFG_OFFSET_W-1:0] cfg_offset(
		input logic [7:0] idx,
		input logic [3:0] n
	);
		logic [CFG_OFFSET_W-1:0] wide;
		wide = {20'h00000, idx};
		cfg_offset = wide << ({1'b0, n} + CFG_SIZE_BASE_EXP);
	endfunction : cfg_offset

endpackage : acr_pkg

// [hdl/acr_desc_policy.sv]
// Purpose: per-descriptor decisions steered by the general capabilities
// Assumes: descriptor attributes arrive on the same clock, one per valid
// Notes:   one cycle from desc_valid to pol_valid, no back-pressure
`timescale 1ns/1ps
module acr_desc_policy (
	input  wire logic clk,           // system clock
	input  wire logic rst_n,         // async reset, active low
	input  wire logic cap_flush_cc,  // flush cache control supported
	input  wire logic cap_mem_cc,    // memory write cache control supported
	input  wire logic cap_overlap,   // overlapping move supported
	input  wire logic cap_block,     // block on fault supported
	input  wire logic desc_valid,    // descriptor attributes valid
	input  wire logic desc_is_move,  // memory move operation
	input  wire logic desc_is_flush, // cache flush operation
	input  wire logic desc_wr_mem,   // operation writes memory
	input  wire logic desc_cc_flag,  // descriptor cache control flag
	input  wire logic desc_overlap,  // source and destination overlap
	input  wire logic desc_block,    // descriptor block-on-fault flag
	input  wire logic queue_block,   // queue block-on-fault enable
	input  wire logic desc_fault,    // page fault on an access
	output logic      pol_valid,     // decisions valid, one-cycle pulse
	output logic      pol_evict,     // flush evicts affected lines
	output logic      pol_cache,     // write steers cache use
	output logic      pol_ovl_err,   // overlap error
	output logic      pol_block,     // fault blocks and waits
	output logic      pol_stop       // fault stops op and is reported
);

	logic valid_r, valid_nxt;
	logic evict_r, evict_nxt;
	logic cache_r, cache_nxt;
	logic ovl_r,   ovl_nxt;
	logic block_r, block_nxt;
	logic stop_r,  stop_nxt;
	logic blk_ok;

	always_comb begin
		valid_nxt = desc_valid;
		evict_nxt = 1'b0;
		cache_nxt = 1'b0;
		ovl_nxt   = 1'b0;
		block_nxt = 1'b0;
		stop_nxt  = 1'b0;
		blk_ok    = 1'b0;
		if (desc_valid) begin
			evict_nxt = desc_is_flush & desc_cc_flag & cap_flush_cc;
			cache_nxt = desc_wr_mem & desc_cc_flag & cap_mem_cc;
			if (desc_overlap) begin
				// only a move may ever overlap, and only if supported
				ovl_nxt = ~desc_is_move | ~cap_overlap;
			end
			// reserved flags are ignored when blocking is unsupported
			blk_ok = cap_block & queue_block & desc_block;
			if (desc_fault) begin
				block_nxt = blk_ok;
				stop_nxt  = ~blk_ok;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r <= 1'b0;
			evict_r <= 1'b0;
			cache_r <= 1'b0;
			ovl_r   <= 1'b0;
			block_r <= 1'b0;
			stop_r  <= 1'b0;
		end else begin
			valid_r <= valid_nxt;
			evict_r <= evict_nxt;
			cache_r <= cache_nxt;
			ovl_r   <= ovl_nxt;
			block_r <= block_nxt;
			stop_r  <= stop_nxt;
		end
	end

	assign pol_valid   = valid_r;
	assign pol_evict   = evict_r;
	assign pol_cache   = cache_r;
	assign pol_ovl_err = ovl_r;
	assign pol_block   = block_r;
	assign pol_stop    = stop_r;

endmodule : acr_desc_policy

// [test/acr_capability_regs_checker.sv]
// Purpose: port assertions for the capability register bank
// Assumes: parameters handed on by the bind match the bound instance
// Notes:   queue gating outputs lag their inputs by one clock
`timescale 1ns/1ps
module acr_capability_regs_checker #(
	parameter logic        CAP_FLUSH_CC = 1'b1, CAP_MEM_CC = 1'b1, CAP_OVERLAP = 1'b1,
	parameter logic        CAP_BLOCK = 1'b1, CAP_OCC_INT = 1'b1, CAP_OCC = 1'b1,
	parameter logic        CAP_PRIO = 1'b1, CAP_ATS = 1'b1, CAP_DEDICATED = 1'b1,
	parameter logic        CAP_SHARED = 1'b1,
	parameter logic [3:0]  CFG_SIZE_N = 4'h0,
	parameter logic [7:0]  NUM_QUEUES = 8'h08,
	parameter logic [15:0] TOTAL_SIZE = 16'h0080
) (
	input wire logic        clk,           // clock
	input wire logic        rst_n,         // async reset
	input wire logic        mmio_rd,       // read strobe
	input wire logic        mmio_wr,       // write strobe
	input wire logic [7:0]  mmio_addr,     // byte address
	input wire logic [63:0] mmio_rdata,    // read data
	input wire logic        mmio_ack,      // access done
	input wire logic        desc_valid,    // descriptor valid
	input wire logic        desc_is_move,  // move op
	input wire logic        desc_is_flush, // flush op
	input wire logic        desc_cc_flag,  // cache flag
	input wire logic        desc_overlap,  // overlap
	input wire logic        desc_block,    // block flag
	input wire logic        queue_block,   // queue block enable
	input wire logic        desc_fault,    // page fault
	input wire logic        pol_evict,     // evict decision
	input wire logic        pol_ovl_err,   // overlap error
	input wire logic        pol_block,     // fault blocks
	input wire logic        pol_stop,      // fault stops
	input wire logic [7:0]  q_index,       // queue selected
	input wire logic        q_shared,      // shared mode asked
	input wire logic        q_mode_bad,    // mode not offered
	input wire logic        q_index_bad,   // no such queue
	input wire logic [27:0] q_cfg_offset   // config offset
);
	localparam logic [63:0] GEN_IMG = {60'h0, CAP_FLUSH_CC, CAP_MEM_CC, CAP_OVERLAP, CAP_BLOCK};
	localparam logic [63:0] QUE_IMG = {10'h000, CAP_OCC_INT, CAP_OCC, CAP_PRIO, CAP_ATS,
		CAP_DEDICATED, CAP_SHARED, 20'h00000, CFG_SIZE_N, NUM_QUEUES, TOTAL_SIZE};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_access; mmio_rd || mmio_wr; endsequence
	sequence s_lone; s_access ##1 !(mmio_rd || mmio_wr); endsequence
	a_ack_next: assert property (s_access |=> mmio_ack)
		else $error("access not acknowledged");
	a_rdata_clear: assert property (
		s_lone |-> mmio_ack ##1 (!mmio_ack && mmio_rdata == 64'h0))
		else $error("read data not released");
	a_gen_image: assert property (
		(mmio_rd && mmio_addr == 8'h10) |=> mmio_rdata == GEN_IMG)
		else $error("general image wrong");
	a_que_image: assert property (
		(mmio_rd && mmio_addr == 8'h20) |=> mmio_rdata == QUE_IMG)
		else $error("queue image wrong");
	a_flush_evict: assert property (desc_valid |=> pol_evict ==
		($past(desc_is_flush) && $past(desc_cc_flag) && CAP_FLUSH_CC)) else $error("evict wrong");
	a_overlap_err: assert property (desc_valid |=>
		pol_ovl_err == ($past(desc_overlap) && (!$past(desc_is_move) || !CAP_OVERLAP)))
		else $error("overlap error wrong");
	a_fault_action: assert property (desc_valid && desc_fault |=>
		pol_stop == !pol_block &&
		pol_block == (CAP_BLOCK && $past(queue_block) && $past(desc_block)))
		else $error("fault action wrong");
	a_cfg_size: assert property (1'b1 |=> q_cfg_offset ==
		({20'h00000, $past(q_index)} << (CFG_SIZE_N + 5))) else $error("config offset wrong");
	a_queue_count: assert property (1'b1 |=>
		q_index_bad == ($past(q_index) >= NUM_QUEUES)) else $error("queue index flag wrong");
	a_mode_flag: assert property (1'b1 |=> q_mode_bad ==
		($past(q_shared) ? !CAP_SHARED : !CAP_DEDICATED)) else $error("mode flag wrong");
endmodule : acr_capability_regs_checker

bind acr_capability_regs acr_capability_regs_checker #(.CAP_FLUSH_CC(CAP_FLUSH_CC),
	.CAP_MEM_CC(CAP_MEM_CC), .CAP_OVERLAP(CAP_OVERLAP), .CAP_BLOCK(CAP_BLOCK),
	.CAP_OCC_INT(CAP_OCC_INT), .CAP_OCC(CAP_OCC), .CAP_PRIO(CAP_PRIO), .CAP_ATS(CAP_ATS),
	.CAP_DEDICATED(CAP_DEDICATED), .CAP_SHARED(CAP_SHARED), .CFG_SIZE_N(CFG_SIZE_N),
	.NUM_QUEUES(NUM_QUEUES), .TOTAL_SIZE(TOTAL_SIZE)) acr_capability_regs_checker_inst (
	.clk(clk), .rst_n(rst_n), .mmio_rd(mmio_rd), .mmio_wr(mmio_wr), .mmio_addr(mmio_addr),
	.mmio_rdata(mmio_rdata), .mmio_ack(mmio_ack), .desc_valid(desc_valid),
	.desc_is_move(desc_is_move), .desc_is_flush(desc_is_flush), .desc_cc_flag(desc_cc_flag),
	.desc_overlap(desc_overlap), .desc_block(desc_block), .queue_block(queue_block),
	.desc_fault(desc_fault), .pol_evict(pol_evict), .pol_ovl_err(pol_ovl_err),
	.pol_block(pol_block), .pol_stop(pol_stop), .q_index(q_index), .q_shared(q_shared),
	.q_mode_bad(q_mode_bad), .q_index_bad(q_index_bad), .q_cfg_offset(q_cfg_offset));

// [test/tb.sv]
// Purpose: self-checking bench for the capability register bank
// Assumes: inputs change and outputs are sampled at the falling edge
// Notes:   capabilities mixed so supported and unsupported gates are both exercised
`timescale 1ns/1ps
module tb;
	localparam logic        F = 1'b1, M = 1'b0, O = 1'b1, B = 1'b1;
	localparam logic [5:0]  QF = 6'h25; // occ_int occ prio ats dedicated shared
	localparam logic [3:0]  N = 4'h3;
	localparam logic [7:0]  NQ = 8'h05;
	localparam logic [15:0] TS = 16'h01C4;
	localparam logic [63:0] GEN = {60'h0, F, M, O, B};
	localparam logic [63:0] QUE = {10'h000, QF, 20'h00000, N, NQ, TS};
	logic        clk = 1'b0, rst_n = 1'b0, mmio_rd = 1'b0, mmio_wr = 1'b0, desc_valid = 1'b0;
	logic [7:0]  mmio_addr = 8'h00, q_index = 8'h00;
	logic [7:0]  dsc = 8'h00; // move flush wr_mem cc overlap block queue_block fault
	logic [63:0] mmio_wdata = 64'hFFFFFFFFFFFFFFFF, mmio_rdata;
	logic        mmio_ack, pol_valid, pol_evict, pol_cache, pol_ovl_err, pol_block, pol_stop;
	logic [15:0] q_occupancy = 16'h0000, q_occ_limit = 16'h0014, q_occ_report;
	logic [3:0]  q_priority = 4'h0, q_prio_eff;
	logic        q_occ_int_en = 1'b0, q_ats_dis = 1'b0, ats_enable = 1'b0, q_shared = 1'b0;
	logic        q_occ_hit, q_ats_use, q_mode_bad, q_index_bad;
	logic [27:0] q_cfg_offset;
	int          mismatches = 0, compares = 0;

	acr_capability_regs #(.CAP_FLUSH_CC(F), .CAP_MEM_CC(M), .CAP_OVERLAP(O), .CAP_BLOCK(B),
		.CAP_OCC_INT(QF[5]), .CAP_OCC(QF[4]), .CAP_PRIO(QF[3]), .CAP_ATS(QF[2]),
		.CAP_DEDICATED(QF[1]), .CAP_SHARED(QF[0]), .CFG_SIZE_N(N), .NUM_QUEUES(NQ),
		.TOTAL_SIZE(TS)) acr_capability_regs_inst (.clk(clk), .rst_n(rst_n),
		.mmio_rd(mmio_rd), .mmio_wr(mmio_wr), .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
		.mmio_rdata(mmio_rdata), .mmio_ack(mmio_ack), .desc_valid(desc_valid),
		.desc_is_move(dsc[7]), .desc_is_flush(dsc[6]), .desc_wr_mem(dsc[5]),
		.desc_cc_flag(dsc[4]), .desc_overlap(dsc[3]), .desc_block(dsc[2]),
		.queue_block(dsc[1]), .desc_fault(dsc[0]), .pol_valid(pol_valid),
		.pol_evict(pol_evict), .pol_cache(pol_cache), .pol_ovl_err(pol_ovl_err),
		.pol_block(pol_block), .pol_stop(pol_stop), .q_index(q_index),
		.q_occupancy(q_occupancy), .q_occ_limit(q_occ_limit), .q_occ_int_en(q_occ_int_en),
		.q_priority(q_priority), .q_ats_dis(q_ats_dis), .ats_enable(ats_enable),
		.q_shared(q_shared), .q_occ_report(q_occ_report), .q_occ_hit(q_occ_hit),
		.q_prio_eff(q_prio_eff), .q_ats_use(q_ats_use), .q_mode_bad(q_mode_bad),
		.q_index_bad(q_index_bad), .q_cfg_offset(q_cfg_offset));

	always #12.5 clk = ~clk;

	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one access, then one idle cycle so no strobe is lowered and raised at once
	task automatic acc(input logic wr, input logic [7:0] a, input string what,
		input logic [63:0] exp);
		int i;
		mmio_rd = !wr;
		mmio_wr = wr;
		mmio_addr = a;
		@(negedge clk);
		mmio_rd = 1'b0;
		mmio_wr = 1'b0;
		for (i = 0; i < 4 && mmio_ack !== 1'b1; i++) @(negedge clk);
		if (i == 4) begin
			mismatches++;
			$display("[ERR] %s expected ack seen none", what);
			test_done();
		end
		chk(what, exp, mmio_rdata);
		@(negedge clk);
	endtask : acc

	initial begin
		logic blk;
		repeat (3) @(negedge clk);
		chk("rdata in reset", 64'h0, mmio_rdata);
		rst_n = 1'b1;
		acc(1'b0, 8'h10, "general", GEN);
		acc(1'b0, 8'h20, "queue", QUE);
		acc(1'b1, 8'h10, "write general", 64'h0);
		acc(1'b1, 8'h20, "write queue", 64'h0);
		acc(1'b0, 8'h10, "general after write", GEN);
		acc(1'b0, 8'h20, "queue after write", QUE);
		acc(1'b0, 8'h18, "unmapped", 64'h0);
		@(negedge clk);
		chk("rdata idle", 64'h0, mmio_rdata);
		$display("registers test done");
		for (int k = 0; k < 256; k++) begin
			dsc = k[7:0];
			desc_valid = 1'b1;
			@(negedge clk);
			blk = dsc[0] & B & dsc[2] & dsc[1];
			chk("policy", {58'h0, 1'b1, dsc[6] & dsc[4] & F, dsc[5] & dsc[4] & M,
				dsc[3] & (~dsc[7] | ~O), blk, dsc[0] & ~blk}, {58'h0, pol_valid,
				pol_evict, pol_cache, pol_ovl_err, pol_block, pol_stop});
		end
		desc_valid = 1'b0;
		@(negedge clk);
		chk("policy idle", 64'h0, {58'h0, pol_valid, pol_evict, pol_cache, pol_ovl_err,
			pol_block, pol_stop});
		$display("policy test done");
		for (int k = 0; k < 16; k++) begin
			q_index = k[7:0];
			q_occupancy = 16'(k * 3);
			q_occ_int_en = k[0];
			q_priority = k[3:0];
			q_ats_dis = k[1];
			ats_enable = k[2];
			q_shared = k[3];
			@(negedge clk);
			chk("queue gating", {12'h000, QF[4] ? q_occupancy : 16'h0000,
				QF[5] & q_occ_int_en & (q_occupancy >= q_occ_limit),
				QF[3] ? q_priority : 4'h0, ats_enable & ~(QF[2] & q_ats_dis),
				q_shared ? ~QF[0] : ~QF[1], q_index >= NQ,
				({20'h00000, q_index} << (N + 5))}, {12'h000, q_occ_report, q_occ_hit,
				q_prio_eff, q_ats_use, q_mode_bad, q_index_bad, q_cfg_offset});
		end
		$display("queue gating test done");
		rst_n = 1'b0;
		@(negedge clk);
		chk("outputs in reset", 64'h0, {5'h00, mmio_ack, pol_valid, pol_evict,
			pol_cache, pol_ovl_err, pol_block, pol_stop, q_occ_report, q_occ_hit,
			q_prio_eff, q_ats_use, q_mode_bad, q_index_bad, q_cfg_offset});
		rst_n = 1'b1;
		acc(1'b0, 8'h20, "queue after reset", QUE);
		$display("reset test done");
		test_done();
	end
endmodule : tb
